// file: bench/pdm_pause_partner.sv
// far-side model: clock source and clock-pause controller
module pdm_pause_partner (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // bench commands
  input  wire logic ask_pause,
  input  wire logic ask_wake,
  // device side
  input  wire logic cpu_halted,
  input  wire logic chip_clock_run,
  input  wire logic clock_pause_acknowledge,
  output logic      clock_pause_request_n,
  output logic      nmi_pin,
  output logic      clock_stopped
);
  timeunit 1ns;
  timeprecision 1ps;
  logic want_wake;
  wire  in_standby = cpu_halted & ~chip_clock_run;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clock_pause_request_n <= 1'b1;
      nmi_pin               <= 1'b0;
      clock_stopped         <= 1'b0;
      want_wake             <= 1'b0;
    end else begin
      if (ask_pause && in_standby)
        clock_pause_request_n <= 1'b0;
      if (!clock_pause_request_n && !clock_pause_acknowledge)
        clock_stopped <= 1'b1;
      // a stopped clock comes back one cycle before the edge
      if (want_wake && clock_stopped) begin
        clock_stopped         <= 1'b0;
        clock_pause_request_n <= 1'b1;
      end else if (want_wake || (ask_wake && !clock_stopped)) begin
        nmi_pin   <= ~nmi_pin;
        want_wake <= 1'b0;
      end
      if (ask_wake && clock_stopped)
        want_wake <= 1'b1;
    end
  end
endmodule

// file: bench/power_down_mode_control_test.sv
// bench for the power-down controller
`include "pdm_map.svh"
module power_down_mode_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  // base 2, overflow select 3
  localparam int DLY = 2 << 3;
  logic        clk = 1'b0, rst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        halt_exec = 1'b0, irq_request = 1'b0, irq_locally_enabled = 1'b1;
  logic [3:0]  irq_level = 4'h5, sr_mask_level = 4'h5;
  logic        dma_addr_error = 1'b0, dma_busy = 1'b0, manual_reset_n = 1'b1;
  logic        ask_pause = 1'b0, ask_wake = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, module_pin_reset;
  logic [31:0] s_axi_rdata;
  logic        nmi_pin, clock_pause_request_n, clock_stopped, clock_pause_acknowledge;
  logic        cpu_halted, chip_clock_run, periph_clock_run, pins_hiz;
  logic        irq_exc_start, dma_err_exc_start, nmi_exc_start, standby_entry_init;
  logic [4:0]  module_clock_en;
  int          err_count = 0, checked = 0, cycles = 0;
  int          irq_cnt = 0, dma_cnt = 0, nmi_cnt = 0;

  pdm_ctrl #(.DLY_BASE(2)) i_pdm_ctrl (.*);
  pdm_pause_partner i_pdm_pause_partner (.*);

  always #25 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (irq_exc_start === 1'b1) irq_cnt++;
    if (dma_err_exc_start === 1'b1) dma_cnt++;
    if (nmi_exc_start === 1'b1) nmi_cnt++;
    if (cycles == 5000) begin
      err_count++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er), "bresp");
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed, "rdata");
    chk(32'(s_axi_rresp), 32'(er), "rresp");
  endtask

  // wake request may ride along with the halt to land inside the blanking
  task automatic halt(input logic w);
    @(posedge clk);
    halt_exec <= 1'b1;
    ask_wake  <= w;
    @(posedge clk);
    halt_exec <= 1'b0;
    ask_wake  <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_cnt(ref int c, input int v, output int n);
    n = 0;
    while (c < v) begin
      @(posedge clk);
      n++;
    end
  endtask

  task end_of_test;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    int n;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(32'(clock_pause_acknowledge), 32'h1, "ack idle");
    rd(`PDM_OFF_PMC, 32'h0, `PDM_RESP_OKAY);
    rd(`PDM_OFF_STAT, 32'h101, `PDM_RESP_OKAY);
    rd(8'h14, 32'h0, `PDM_RESP_SLVERR);
    wr(8'h14, 32'hFF, `PDM_RESP_SLVERR);
    wr(`PDM_OFF_PMC, 32'h1F, `PDM_RESP_OKAY);
    repeat (2) @(posedge clk);
    chk(32'(module_clock_en), 32'h0, "gate");
    chk(32'(module_pin_reset), 32'h3, "pin reset");
    wr(`PDM_OFF_PMC, 32'h0, `PDM_RESP_OKAY);
    repeat (2) @(posedge clk);
    chk(32'(module_clock_en), 32'h1F, "ungate");
    // sleep: masked and locally disabled requests must not wake
    halt(1'b0);
    chk(32'(cpu_halted), 32'h1, "sleep");
    chk(32'(periph_clock_run), 32'h1, "periph run");
    irq_request <= 1'b1;
    repeat (6) @(posedge clk);
    chk(32'(cpu_halted + irq_cnt), 32'h1, "masked");
    irq_level           <= 4'h9;
    irq_locally_enabled <= 1'b0;
    repeat (6) @(posedge clk);
    chk(32'(cpu_halted + irq_cnt), 32'h1, "disabled");
    irq_locally_enabled <= 1'b1;
    wait_cnt(irq_cnt, 1, n);
    irq_request <= 1'b0;
    @(posedge clk);
    chk(32'(cpu_halted), 32'h0, "irq wake");
    halt(1'b0);
    dma_addr_error <= 1'b1;
    @(posedge clk);
    dma_addr_error <= 1'b0;
    wait_cnt(dma_cnt, 1, n);
    @(posedge clk);
    chk(32'(cpu_halted), 32'h0, "dma wake");
    // manual reset out of sleep clears the stop bits too
    wr(`PDM_OFF_PMC, 32'h1F, `PDM_RESP_OKAY);
    halt(1'b0);
    manual_reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    manual_reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk(32'(cpu_halted), 32'h0, "mreset");
    chk(32'(module_clock_en), 32'h1F, "mreset gate");
    // the dma stop bit cannot be set while the engine transfers
    dma_busy <= 1'b1;
    wr(`PDM_OFF_PMC, 32'h10, `PDM_RESP_OKAY);
    rd(`PDM_OFF_PMC, 32'h0, `PDM_RESP_OKAY);
    dma_busy <= 1'b0;
    wr(`PDM_OFF_WDCS, 32'h20, `PDM_RESP_OKAY);
    wr(`PDM_OFF_PMC, 32'h80, `PDM_RESP_OKAY);
    rd(`PDM_OFF_PMC, 32'h0, `PDM_RESP_OKAY);
    wr(`PDM_OFF_WDCS, 32'h03, `PDM_RESP_OKAY);
    wr(`PDM_OFF_ICR, 32'h01, `PDM_RESP_OKAY);
    wr(`PDM_OFF_PMC, 32'h80, `PDM_RESP_OKAY);
    rd(`PDM_OFF_PMC, 32'h80, `PDM_RESP_OKAY);
    // standby: a rise during blanking and a fall are both ignored
    halt(1'b1);
    chk(32'(standby_entry_init), 32'h1, "init");
    chk(32'({cpu_halted, chip_clock_run, periph_clock_run, pins_hiz}), 32'h8, "standby");
    ask_wake <= 1'b1;
    @(posedge clk);
    ask_wake <= 1'b0;
    repeat (40) @(posedge clk);
    chk(32'(nmi_cnt + chip_clock_run), 32'h0, "blank");
    ask_pause <= 1'b1;
    @(posedge clk);
    ask_pause <= 1'b0;
    n = 0;
    while (clock_pause_acknowledge !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    repeat (10) @(posedge clk);
    chk(32'({clock_pause_acknowledge, clock_stopped}), 32'h1, "pause");
    ask_wake <= 1'b1;
    @(posedge clk);
    ask_wake <= 1'b0;
    wait_cnt(nmi_cnt, 1, n);
    chk(32'(n >= DLY && n <= DLY + 12), 32'h1, "delay");
    @(posedge clk);
    chk(32'({clock_pause_acknowledge, chip_clock_run}), 32'h3, "resume");
    rd(`PDM_OFF_WDCS, 32'h03, `PDM_RESP_OKAY);
    // second standby woken by a falling edge
    wr(`PDM_OFF_ICR, 32'h00, `PDM_RESP_OKAY);
    wr(`PDM_OFF_PMC, 32'hC0, `PDM_RESP_OKAY);
    rd(`PDM_OFF_PMC, 32'hC0, `PDM_RESP_OKAY);
    halt(1'b0);
    chk(32'(pins_hiz), 32'h1, "hiz");
    // a pause asked while the watchdog runs waits until it is halted
    wr(`PDM_OFF_WDCS, 32'h23, `PDM_RESP_OKAY);
    ask_pause <= 1'b1;
    repeat (10) @(posedge clk);
    chk(32'(clock_pause_acknowledge), 32'h1, "refused");
    ask_pause <= 1'b0;
    wr(`PDM_OFF_WDCS, 32'h03, `PDM_RESP_OKAY);
    repeat (8) @(posedge clk);
    ask_wake <= 1'b1;
    @(posedge clk);
    ask_wake <= 1'b0;
    wait_cnt(nmi_cnt, 2, n);
    chk(32'(n >= DLY && clock_pause_acknowledge), 32'h1, "fall");
    end_of_test();
  end
endmodule

// file: logic/pdm_ctrl.sv
// power-down mode controller: sleep, standby, clock pause and module standby
// Operation
// - halt with select 0 enters sleep
// - interrupt, DMA error or resets end sleep
// - waking interrupt starts exception processing
// - masked or locally disabled interrupt keeps sleep
// - DMA address error ends sleep, starts exception; here only if no interrupt is taken in the same cycle
// - halt with select 1 enters standby
// - ignore NMI for five cycles from halt
// - CPU and controller registers keep values
// - standby entry initialises DMA control registers
// - standby clears watchdog bits 7-5, reset status
// - NMI edge or resets end standby
// - NMI edge waits watchdog delay, then wakes
// - edge select: 0 falling, 1 rising
// - refuse clock pause while watchdog runs
// - acknowledge low when ready; partner then stops
// - after pause, delay then acknowledge high
// - cache RAM contents lost across standby
// - stop bit gates clock; timer, serial reset
// - module standby ends on clear or resets
// - standby select refuses 1 while watchdog runs
// - stop bits: 4 DMA,3 mul,2 div,1 timer,0 serial
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`include "pdm_map.svh"
module pdm_ctrl #(
  parameter int AW       = 8,
  parameter int CW       = 16,
  parameter int DLY_BASE = `PDM_DLY_BASE
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // axi4-lite write
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  // axi4-lite read
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // cpu and peripheral events
  input  wire logic          halt_exec,
  input  wire logic          irq_request,
  input  wire logic [3:0]    irq_level,
  input  wire logic [3:0]    sr_mask_level,
  input  wire logic          irq_locally_enabled,
  input  wire logic          dma_addr_error,
  input  wire logic          dma_busy,
  // pins
  input  wire logic          nmi_pin,
  input  wire logic          clock_pause_request_n,
  input  wire logic          manual_reset_n,
  // mode outputs
  output logic               cpu_halted,
  output logic               chip_clock_run,
  output logic               periph_clock_run,
  output logic               pins_hiz,
  output logic               irq_exc_start,
  output logic               dma_err_exc_start,
  output logic               nmi_exc_start,
  output logic               standby_entry_init,
  output logic [4:0]         module_clock_en,
  output logic [1:0]         module_pin_reset,
  output logic               clock_pause_acknowledge
);
  initial begin
    if (AW < 5 || DLY_BASE < 1 || (DLY_BASE * 128) >= (2 ** CW))
      $error("pdm_ctrl: parameters cannot be served");
  end

  // two-flop synchronisers for the three pins
  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  logic       nmi_prev;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_s1   <= 3'h7;
      pin_s2   <= 3'h7;
      nmi_prev <= 1'b1;
    end else begin
      pin_s1   <= {manual_reset_n, clock_pause_request_n, nmi_pin};
      pin_s2   <= pin_s1;
      nmi_prev <= pin_s2[0];
    end
  end
  wire nmi_s    = pin_s2[0];
  wire pause_rq = ~pin_s2[1];
  wire mreset   = ~pin_s2[2];

  // registers
  logic [7:0] pmc;
  logic [7:0] interrupt_control_reg;
  logic [7:0] wdcs;
  logic [7:0] wdrs;
  pdm_pkg::pdm_state_e state;
  pdm_pkg::pdm_state_e next_state;
  logic [2:0] blank;

  wire wd_run    = wdcs[`PDM_WD_RUN_BIT];
  wire edge_sel  = interrupt_control_reg[`PDM_EDGE_BIT];
  wire nmi_rise  = nmi_s & ~nmi_prev;
  wire nmi_fall  = ~nmi_s & nmi_prev;
  wire nmi_edge  = edge_sel ? nmi_rise : nmi_fall;
  wire nmi_ok    = nmi_edge && blank == 3'h0;
  wire irq_take  = irq_request && irq_locally_enabled
                   && irq_level > sr_mask_level;

  // axi write path: address and data taken in either order
  logic [AW-1:0] aw_addr;
  logic [7:0]    w_byte;
  logic          w_lane;
  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs  = s_axi_wvalid & s_axi_wready;
  wire do_wr = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  wire wr_pmc  = do_wr && w_lane && aw_addr[AW-1:2] == `PDM_OFF_PMC  >> 2;
  wire wr_icr  = do_wr && w_lane && aw_addr[AW-1:2] == `PDM_OFF_ICR  >> 2;
  wire wr_wdcs = do_wr && w_lane && aw_addr[AW-1:2] == `PDM_OFF_WDCS >> 2;
  wire wr_wdrs = do_wr && w_lane && aw_addr[AW-1:2] == `PDM_OFF_WDRS >> 2;
  wire wr_hit  = aw_addr[AW-1:2] <= `PDM_OFF_WDRS >> 2;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PDM_RESP_OKAY;
      aw_addr       <= '0;
      w_byte        <= `PDM_RESET_BYTE;
      w_lane        <= 1'b0;
    end else begin
      if (aw_hs) begin
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_hs) begin
        w_byte       <= s_axi_wdata[7:0];
        w_lane       <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `PDM_RESP_OKAY : `PDM_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // axi read path, one cycle from address to data
  wire [AW-3:0] ridx = s_axi_araddr[AW-1:2];
  wire [31:0] rd_mux =
    ridx == `PDM_OFF_PMC  >> 2 ? {24'h000000, pmc & `PDM_PMC_MASK} :
    ridx == `PDM_OFF_ICR  >> 2 ? {24'h000000, interrupt_control_reg} :
    ridx == `PDM_OFF_WDCS >> 2 ? {24'h000000, wdcs} :
    ridx == `PDM_OFF_WDRS >> 2 ? {24'h000000, wdrs} :
    {23'h000000, clock_pause_acknowledge, blank, 1'b0, state};
  wire rd_hit = ridx <= `PDM_OFF_STAT >> 2;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `PDM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_hit ? rd_mux : 32'h00000000;
      s_axi_rresp   <= rd_hit ? `PDM_RESP_OKAY : `PDM_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // settling delay, doubled per overflow select step
  logic dly_busy;
  logic dly_done;
  wire  dly_start = next_state == pdm_pkg::PDM_WAKE && state != pdm_pkg::PDM_WAKE;
  wire [CW-1:0] dly_load = CW'(DLY_BASE) << wdcs[`PDM_WD_SEL_MSB:0];
  pdm_delay_timer #(.CW(CW)) u_delay (
    .clk   (clk),
    .rst   (rst),
    .start (dly_start),
    .load  (dly_load),
    .busy  (dly_busy),
    .done  (dly_done)
  );

  // mode sequencing
  wire enter_sleep = halt_exec && !pmc[`PDM_SBY_BIT];
  wire enter_stby  = halt_exec && pmc[`PDM_SBY_BIT];
  always_comb begin
    next_state = state;
    unique case (state)
      pdm_pkg::PDM_RUN: begin
        if (enter_stby) next_state = pdm_pkg::PDM_STANDBY;
        else if (enter_sleep) next_state = pdm_pkg::PDM_SLEEP;
      end
      pdm_pkg::PDM_SLEEP: begin
        if (irq_take || dma_addr_error) next_state = pdm_pkg::PDM_RUN;
      end
      pdm_pkg::PDM_STANDBY: begin
        if (nmi_ok) next_state = pdm_pkg::PDM_WAKE;
      end
      pdm_pkg::PDM_WAKE: begin
        if (dly_done) next_state = pdm_pkg::PDM_RUN;
      end
    endcase
    if (mreset) next_state = pdm_pkg::PDM_RUN;
  end

  wire stby_entry = state == pdm_pkg::PDM_RUN && enter_stby && !mreset;
  wire [4:0] mstp_wr = w_byte[`PDM_MSTP_MSB:0];
  // stopping the DMA engine mid-transfer would strand it, so a set while dma_busy is dropped
  wire mstp4_ok = !dma_busy || pmc[`PDM_MSTP_DMA];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= pdm_pkg::PDM_RUN;
      pmc   <= `PDM_RESET_BYTE;
      interrupt_control_reg   <= `PDM_RESET_BYTE;
      wdcs  <= `PDM_RESET_BYTE;
      wdrs  <= `PDM_RESET_BYTE;
      blank <= 3'h0;
    end else if (mreset) begin
      state <= pdm_pkg::PDM_RUN;
      pmc   <= `PDM_RESET_BYTE;
      interrupt_control_reg   <= `PDM_RESET_BYTE;
      wdcs  <= `PDM_RESET_BYTE;
      wdrs  <= `PDM_RESET_BYTE;
      blank <= 3'h0;
    end else begin
      state <= next_state;
      if (stby_entry) blank <= `PDM_NMI_BLANK;
      else if (blank != 3'h0) blank <= blank - 3'h1;
      if (wr_pmc) begin
        pmc[`PDM_SBY_BIT] <= wd_run ? pmc[`PDM_SBY_BIT] : w_byte[`PDM_SBY_BIT];
        pmc[`PDM_HIZ_BIT] <= w_byte[`PDM_HIZ_BIT];
        pmc[`PDM_MSTP_MSB:0] <= mstp_wr;
        if (!mstp4_ok) pmc[`PDM_MSTP_DMA] <= 1'b0;
      end
      if (wr_icr) interrupt_control_reg <= w_byte;
      // select bits survive standby so the wake delay stays programmed
      if (stby_entry) wdcs <= wdcs & `PDM_WD_INIT_MASK;
      else if (wr_wdcs) wdcs <= w_byte;
      if (stby_entry) wdrs <= `PDM_RESET_BYTE;
      else if (wr_wdrs) wdrs <= w_byte;
    end
  end

  // registered outputs
  wire nx_run   = next_state == pdm_pkg::PDM_RUN;
  wire nx_sleep = next_state == pdm_pkg::PDM_SLEEP;
  wire [4:0] nx_stop = mreset ? 5'h00 : pmc[`PDM_MSTP_MSB:0];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpu_halted              <= 1'b0;
      chip_clock_run          <= 1'b1;
      periph_clock_run        <= 1'b1;
      pins_hiz                <= 1'b0;
      irq_exc_start           <= 1'b0;
      dma_err_exc_start       <= 1'b0;
      nmi_exc_start           <= 1'b0;
      standby_entry_init      <= 1'b0;
      module_clock_en         <= 5'h1F;
      module_pin_reset        <= 2'h0;
      clock_pause_acknowledge <= 1'b1;
    end else begin
      cpu_halted         <= !nx_run;
      chip_clock_run     <= nx_run || nx_sleep;
      periph_clock_run   <= nx_run || nx_sleep;
      pins_hiz           <= !nx_run && !nx_sleep && pmc[`PDM_HIZ_BIT];
      irq_exc_start      <= state == pdm_pkg::PDM_SLEEP && irq_take && !mreset;
      dma_err_exc_start  <= state == pdm_pkg::PDM_SLEEP && !irq_take
                            && dma_addr_error && !mreset;
      nmi_exc_start      <= state == pdm_pkg::PDM_WAKE && dly_done && !mreset;
      standby_entry_init <= stby_entry;
      module_clock_en    <= ~nx_stop;
      module_pin_reset   <= {nx_stop[`PDM_MSTP_FRT], nx_stop[`PDM_MSTP_SCI]};
      if (mreset || (state == pdm_pkg::PDM_WAKE && dly_done))
        clock_pause_acknowledge <= 1'b1;
      else if (state == pdm_pkg::PDM_STANDBY && pause_rq && !wd_run)
        clock_pause_acknowledge <= 1'b0;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_sleep_entry;
    state == pdm_pkg::PDM_RUN && enter_sleep && !mreset |=> state == pdm_pkg::PDM_SLEEP
      && cpu_halted && periph_clock_run;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");
  property p_masked_irq;
    state == pdm_pkg::PDM_SLEEP && !irq_take && !dma_addr_error && !mreset
      |=> state == pdm_pkg::PDM_SLEEP;
  endproperty
  a_masked_irq: assert property (p_masked_irq) else $error("sleep left without cause");
  property p_irq_exc;
    state == pdm_pkg::PDM_SLEEP && irq_take && !mreset
      |=> irq_exc_start && state == pdm_pkg::PDM_RUN && !cpu_halted;
  endproperty
  a_irq_exc: assert property (p_irq_exc) else $error("interrupt wake missing");
  property p_dma_err;
    state == pdm_pkg::PDM_SLEEP && dma_addr_error && !irq_take && !mreset |=> dma_err_exc_start;
  endproperty
  a_dma_err: assert property (p_dma_err) else $error("dma error wake missing");
  property p_nmi_blank;
    stby_entry |=> (state != pdm_pkg::PDM_WAKE) [*5];
  endproperty
  a_nmi_blank: assert property (p_nmi_blank) else $error("nmi taken in blank window");
  property p_standby_clock;
    state == pdm_pkg::PDM_STANDBY && !mreset
      |=> !chip_clock_run && !periph_clock_run && cpu_halted;
  endproperty
  a_standby_clock: assert property (p_standby_clock) else $error("clock runs in standby");
  property p_wdt_init;
    stby_entry |=> !wd_run && wdrs == `PDM_RESET_BYTE
      && wdcs[`PDM_WD_SEL_MSB:0] == $past(wdcs[`PDM_WD_SEL_MSB:0]);
  endproperty
  a_wdt_init: assert property (p_wdt_init) else $error("watchdog bits wrong at standby");
  property p_sby_refused;
    wr_pmc && wd_run && !mreset && !pmc[`PDM_SBY_BIT] |=> !pmc[`PDM_SBY_BIT];
  endproperty
  a_sby_refused: assert property (p_sby_refused) else $error("select set while running");
  property p_pause_refused;
    wd_run && clock_pause_acknowledge |=> clock_pause_acknowledge;
  endproperty
  a_pause_refused: assert property (p_pause_refused) else $error("pause taken with watchdog");
  property p_ack_low_hold;
    !clock_pause_acknowledge && !mreset && state != pdm_pkg::PDM_WAKE |=> !clock_pause_acknowledge;
  endproperty
  a_ack_low_hold: assert property (p_ack_low_hold) else $error("ack rose early");
  // the delay length itself is checked inside the timer, which counts it
  property p_wake_delay;
    state == pdm_pkg::PDM_WAKE && !mreset |-> (dly_busy || dly_done) ##1
      (!$past(dly_done) || (nmi_exc_start && chip_clock_run && clock_pause_acknowledge));
  endproperty
  a_wake_delay: assert property (p_wake_delay) else $error("wake delay wrong");
  property p_module_gate;
    !mreset |=> module_clock_en == ~$past(pmc[`PDM_MSTP_MSB:0]);
  endproperty
  a_module_gate: assert property (p_module_gate) else $error("module clock gate wrong");

  c_sleep_wake: cover property (state == pdm_pkg::PDM_SLEEP ##1 irq_exc_start);
  c_nmi_wake:   cover property (nmi_exc_start);
  c_pause:      cover property (!clock_pause_acknowledge ##[1:100] clock_pause_acknowledge);
  c_mstp:       cover property (module_pin_reset != 2'h0);
endmodule

// file: logic/pdm_delay_timer.sv
// settling delay down-counter, one done pulse per start
module pdm_delay_timer #(
  parameter int CW = 16
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // control
  input  wire logic          start,
  input  wire logic [CW-1:0] load,
  output logic               busy,
  output logic               done
);
  logic [CW-1:0] count;
  // helper: cycles since start, so a long delay is checked without a delay range
  logic [CW:0]   elapsed;
  logic [CW:0]   due;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count <= load;
        busy  <= 1'b1;
      end else if (busy && count == '0) begin
        busy <= 1'b0;
        done <= 1'b1;
      end else if (busy) begin
        count <= count - CW'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      elapsed <= '0;
      due     <= '0;
    end else if (start) begin
      elapsed <= '0;
      due     <= {1'b0, load};
    end else if (busy) begin
      elapsed <= elapsed + (CW+1)'(1);
    end
  end

  property p_delay_len;
    @(posedge clk) disable iff (rst)
      busy |-> elapsed <= due && (count == '0) == (elapsed == due);
  endproperty
  a_delay_len: assert property (p_delay_len) else $error("settling delay length wrong");
endmodule

// file: logic/pdm_map.svh
// register offsets, field positions, reset values and counts of the power-down controller
`ifndef PDM_MAP_SVH
`define PDM_MAP_SVH
`define PDM_OFF_PMC       8'h00
`define PDM_OFF_ICR       8'h04
`define PDM_OFF_WDCS      8'h08
`define PDM_OFF_WDRS      8'h0C
`define PDM_OFF_STAT      8'h10
`define PDM_SBY_BIT       7
`define PDM_HIZ_BIT       6
`define PDM_MSTP_MSB      4
`define PDM_MSTP_DMA      4
`define PDM_MSTP_FRT      1
`define PDM_MSTP_SCI      0
`define PDM_PMC_MASK      8'hDF
`define PDM_EDGE_BIT      0
`define PDM_WD_RUN_BIT    5
`define PDM_WD_INIT_MASK  8'h1F
`define PDM_WD_SEL_MSB    2
`define PDM_RESET_BYTE    8'h00
`define PDM_NMI_BLANK     3'h4
`define PDM_RESP_OKAY     2'h0
`define PDM_RESP_SLVERR   2'h2
`define PDM_DLY_BASE      256
`endif

// file: logic/pdm_pkg.sv
// types shared by the power-down controller
package pdm_pkg;
  typedef enum logic [3:0] {
    PDM_RUN     = 4'h1,
    PDM_SLEEP   = 4'h2,
    PDM_STANDBY = 4'h4,
    PDM_WAKE    = 4'h8
  } pdm_state_e;
endpackage
